// ### logic/scx_pkg.sv
// Package with register map, field layout, reset values and sizes of the scan exposure block.
//Contract
//- Bitmap may be mirrored about X, Y or both by two flip selections.
//- With bitmap mode off, every position inside the object rectangle is exposed.
//- Fill mode tiles the field with bitmap copies, partial copies allowed.
//- Inversion complements each value: binary 0 to 1, grey 255 to 0.
//- Pulse-width mode sets laser duty proportional to pixel grey value.
//- Real mode drives an analog level from each pixel grey value.
//- Greater-than mode exposes only pixels above the threshold.
//- Equality mode exposes only pixels equal to the threshold.
//- Incrementing compare modes add the auto-increment step after every scan.
//- Layer mode uses each bit of a pixel word as one of 32 layers.
//- Scan source counts one event when the scan process starts.
//- Field source counts one event after each completed scan field.
//- Line source counts one event after each completed line.
//- Encoder source counts one event per four encoder edges.
//- External trigger source counts one event per trigger on its input.
//- Timer source counts one event each time the timer period elapses.
//- Resets of the other two shifters can count as events on an axis.
//- An axis shifts once its event count from 0 reaches the set count; the code shifts only when the count exceeds it.
//- A read-only counter holds completed scans of the process.
//- A read-only counter holds the current object number.
//- Current X, Y and Z shifter positions are readable status.
//- Each shift moves the axis by its configured shift value.
//- An axis resets once its reset count from 0 reaches the reset count; the code resets only when the count exceeds it.
package scx_pkg;
	localparam int AXES = 3;
	localparam int BMP_SIDE_BITS = 2;
	localparam int BMP_WORDS = 16;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_OBJ_SIZE = 8'h04;
	localparam logic [7:0] A_THRESH = 8'h08;
	localparam logic [7:0] A_AUTO_INC = 8'h0C;
	localparam logic [7:0] A_TIMER = 8'h10;
	localparam logic [7:0] A_BMP_ADDR = 8'h14;
	localparam logic [7:0] A_BMP_DATA = 8'h18;
	localparam logic [7:0] A_SCAN_COUNT = 8'h1C;
	localparam logic [7:0] A_OBJ_COUNT = 8'h20;
	localparam logic [1:0] A_AXIS_BLOCK = 2'h1;
	localparam logic [1:0] S_SET_CFG = 2'h0;
	localparam logic [1:0] S_RES_CFG = 2'h1;
	localparam logic [1:0] S_SHIFT = 2'h2;
	localparam logic [1:0] S_POS = 2'h3;
	localparam int C_FLIP_X = 0;
	localparam int C_FLIP_Y = 1;
	localparam int C_BMP_EN = 2;
	localparam int C_FILL = 3;
	localparam int C_INVERT = 4;
	localparam int C_MODE_LO = 5;
	localparam int C_LAYER_LO = 8;
	localparam int C_LAYER_EN = 13;
	localparam int SRC_SCAN = 0;
	localparam int SRC_FIELD = 1;
	localparam int SRC_LINE = 2;
	localparam int SRC_QUAD = 3;
	localparam int SRC_TRIG = 4;
	localparam int SRC_TIMER = 5;
	localparam int SRC_RES_A = 6;
	localparam int SRC_RES_B = 7;
	localparam int CFG_N_LO = 16;
	localparam logic [1:0] QUAD_LAST = 2'h3;
	localparam logic [7:0] GREY_MAX = 8'hFF;
	localparam logic [13:0] CTRL_RESET = 14'h0000;
	localparam logic [15:0] TIMER_RESET = 16'h03E8;
	typedef enum logic [2:0] {
		MODE_BIN = 3'b000,
		MODE_PWM = 3'b001,
		MODE_REAL = 3'b010,
		MODE_GT = 3'b011,
		MODE_EQ = 3'b100,
		MODE_LT_INC = 3'b101,
		MODE_GT_INC = 3'b110,
		MODE_EQ_INC = 3'b111
	} scx_mode_t;
endpackage : scx_pkg

// ### logic/scx_top.sv
// Exposure decision, grey modulation, shifter event logic and APB register file.
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module scx_top (
	input wire logic clock,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pix_valid,
	input wire logic [15:0] pix_x,
	input wire logic [15:0] pix_y,
	input wire logic scan_start,
	input wire logic field_done,
	input wire logic line_done,
	input wire logic scan_done,
	input wire logic obj_done,
	input wire logic enc_edge,
	input wire logic ext_trig,
	output logic laser_on,
	output logic [7:0] laser_level,
	output logic [2:0] shift_pulse,
	output logic [2:0] shifter_reset
);
	typedef struct packed {
		logic [13:0] ctrl;
		logic [15:0] obj_w;
		logic [15:0] obj_h;
		logic [7:0] thr;
		logic [7:0] inc;
		logic [15:0] tper;
		logic [15:0] tcnt;
		logic [1:0] qcnt;
		logic [3:0] baddr;
		logic [15:0][31:0] bmp;
		logic [31:0] scan_cnt;
		logic [31:0] obj_cnt;
		logic [2:0][31:0] set_cfg;
		logic [2:0][31:0] res_cfg;
		logic [2:0][15:0] shv;
		logic [2:0][15:0] pos;
		logic [2:0][15:0] scnt;
		logic [2:0][15:0] rcnt;
		logic [2:0] shp;
		logic [2:0] rsp;
		logic [7:0] pwm;
		logic laser;
		logic [7:0] level;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} scx_state_t;

	scx_state_t st_reg;
	scx_state_t st_next;

	function automatic logic [3:0] scx_pop(input logic [7:0] v);
		logic [3:0] s;
		s = 4'h0;
		for (int i = 0; i < 8; i++) begin
			s = s + {3'h0, v[i]};
		end
		return s;
	endfunction : scx_pop

	logic quad_tick;
	logic timer_tick;
	logic [7:0] kinds;
	assign quad_tick = enc_edge && (st_reg.qcnt == scx_pkg::QUAD_LAST);
	assign timer_tick = (st_reg.tcnt >= st_reg.tper);
	assign kinds = {2'h0, timer_tick, ext_trig, quad_tick, line_done, field_done, scan_start};

	// Shifter resets of the previous cycle feed the other axes, which keeps the loop registered.
	logic [2:0][3:0] set_events;
	logic [2:0][3:0] res_events;
	genvar ax;
	generate
		for (ax = 0; ax < scx_pkg::AXES; ax++) begin : g_axis
			logic [7:0] occ;
			assign occ = kinds | {st_reg.rsp[(ax + 2) % 3], st_reg.rsp[(ax + 1) % 3], 6'h00};
			assign set_events[ax] = scx_pop(occ & st_reg.set_cfg[ax][7:0]);
			assign res_events[ax] = scx_pop(occ & st_reg.res_cfg[ax][7:0]);
		end
	endgenerate

	// Pixel lookup with flips and tiling.
	logic [1:0] bx;
	logic [1:0] by;
	logic in_bmp;
	logic in_obj;
	logic [31:0] word;
	logic bit_val;
	logic [7:0] grey;
	scx_pkg::scx_mode_t mode;
	logic inc_mode;
	assign mode = scx_pkg::scx_mode_t'(st_reg.ctrl[scx_pkg::C_MODE_LO +: 3]);
	assign inc_mode = (mode == scx_pkg::MODE_LT_INC) || (mode == scx_pkg::MODE_GT_INC) ||
		(mode == scx_pkg::MODE_EQ_INC);
	assign bx = st_reg.ctrl[scx_pkg::C_FLIP_Y] ? ~pix_x[1:0] : pix_x[1:0];
	assign by = st_reg.ctrl[scx_pkg::C_FLIP_X] ? ~pix_y[1:0] : pix_y[1:0];
	assign in_bmp = st_reg.ctrl[scx_pkg::C_FILL] ||
		((pix_x[15:scx_pkg::BMP_SIDE_BITS] == 14'h0000) &&
		(pix_y[15:scx_pkg::BMP_SIDE_BITS] == 14'h0000));
	assign in_obj = (pix_x < st_reg.obj_w) && (pix_y < st_reg.obj_h);
	assign word = st_reg.bmp[{by, bx}];
	assign bit_val = (st_reg.ctrl[scx_pkg::C_LAYER_EN] ? word[st_reg.ctrl[scx_pkg::C_LAYER_LO +: 5]]
		: word[0]) ^ st_reg.ctrl[scx_pkg::C_INVERT];
	assign grey = st_reg.ctrl[scx_pkg::C_INVERT] ? scx_pkg::GREY_MAX - word[7:0] : word[7:0];

	logic [31:0] rdata;
	logic rmiss;
	logic [1:0] rax;
	assign rax = paddr[5:4];

	always_comb begin
		rdata = 32'h0000_0000;
		rmiss = 1'b0;
		if (paddr[7:6] == scx_pkg::A_AXIS_BLOCK) begin
			if (rax == 2'h3) begin
				rmiss = 1'b1;
			end else begin
				case (paddr[3:2])
					scx_pkg::S_SET_CFG: rdata = st_reg.set_cfg[rax];
					scx_pkg::S_RES_CFG: rdata = st_reg.res_cfg[rax];
					scx_pkg::S_SHIFT: rdata = {16'h0000, st_reg.shv[rax]};
					scx_pkg::S_POS: rdata = {16'h0000, st_reg.pos[rax]};
					default: rmiss = 1'b1;
				endcase
			end
		end else begin
			case (paddr)
				scx_pkg::A_CTRL: rdata = {18'h00000, st_reg.ctrl};
				scx_pkg::A_OBJ_SIZE: rdata = {st_reg.obj_h, st_reg.obj_w};
				scx_pkg::A_THRESH: rdata = {24'h000000, st_reg.thr};
				scx_pkg::A_AUTO_INC: rdata = {24'h000000, st_reg.inc};
				scx_pkg::A_TIMER: rdata = {16'h0000, st_reg.tper};
				scx_pkg::A_BMP_ADDR: rdata = {28'h0000000, st_reg.baddr};
				scx_pkg::A_BMP_DATA: rdata = st_reg.bmp[st_reg.baddr];
				scx_pkg::A_SCAN_COUNT: rdata = st_reg.scan_cnt;
				scx_pkg::A_OBJ_COUNT: rdata = st_reg.obj_cnt;
				default: rmiss = 1'b1;
			endcase
		end
	end

	always_comb begin
		st_next = st_reg;
		st_next.shp = 3'b000;
		st_next.rsp = 3'b000;
		st_next.pwm = st_reg.pwm + 8'h01;
		st_next.tcnt = timer_tick ? 16'h0001 : st_reg.tcnt + 16'h0001;
		if (enc_edge) begin
			st_next.qcnt = st_reg.qcnt + 2'h1;
		end
		if (scan_done) begin
			st_next.scan_cnt = st_reg.scan_cnt + 32'h0000_0001;
			if (inc_mode) begin
				st_next.thr = st_reg.thr + st_reg.inc;
			end
		end
		if (obj_done) begin
			st_next.obj_cnt = st_reg.obj_cnt + 32'h0000_0001;
		end
		for (int a = 0; a < scx_pkg::AXES; a++) begin
			if (set_events[a] != 4'h0) begin
				if ((st_reg.scnt[a] + {12'h000, set_events[a]}) >
					st_reg.set_cfg[a][scx_pkg::CFG_N_LO +: 16]) begin
					st_next.scnt[a] = 16'h0000;
					st_next.shp[a] = 1'b1;
					st_next.pos[a] = st_reg.pos[a] + st_reg.shv[a];
				end else begin
					st_next.scnt[a] = st_reg.scnt[a] + {12'h000, set_events[a]};
				end
			end
			// A reset in the same cycle as a shift wins, so the axis lands on its start value.
			if (res_events[a] != 4'h0) begin
				if ((st_reg.rcnt[a] + {12'h000, res_events[a]}) >
					st_reg.res_cfg[a][scx_pkg::CFG_N_LO +: 16]) begin
					st_next.rcnt[a] = 16'h0000;
					st_next.scnt[a] = 16'h0000;
					st_next.rsp[a] = 1'b1;
					st_next.pos[a] = 16'h0000;
				end else begin
					st_next.rcnt[a] = st_reg.rcnt[a] + {12'h000, res_events[a]};
				end
			end
		end
		st_next.laser = 1'b0;
		st_next.level = 8'h00;
		if (pix_valid && in_obj) begin
			if (!st_reg.ctrl[scx_pkg::C_BMP_EN]) begin
				st_next.laser = 1'b1;
				st_next.level = scx_pkg::GREY_MAX;
			end else if (in_bmp) begin
				case (mode)
					scx_pkg::MODE_BIN: st_next.laser = bit_val;
					scx_pkg::MODE_PWM: st_next.laser = (st_reg.pwm < grey);
					scx_pkg::MODE_REAL: begin
						st_next.laser = (grey != 8'h00);
						st_next.level = grey;
					end
					scx_pkg::MODE_GT,
					scx_pkg::MODE_GT_INC: st_next.laser = (grey > st_reg.thr);
					scx_pkg::MODE_EQ,
					scx_pkg::MODE_EQ_INC: st_next.laser = (grey == st_reg.thr);
					scx_pkg::MODE_LT_INC: st_next.laser = (grey < st_reg.thr);
					default: st_next.laser = 1'b0;
				endcase
				if (mode != scx_pkg::MODE_REAL) begin
					st_next.level = st_next.laser ? scx_pkg::GREY_MAX : 8'h00;
				end
			end
		end
		// One wait state: the access phase answers on its second cycle.
		st_next.pready = 1'b0;
		st_next.pslverr = 1'b0;
		if (psel && penable && !st_reg.pready) begin
			st_next.pready = 1'b1;
			st_next.pslverr = rmiss;
			st_next.prdata = pwrite ? 32'h0000_0000 : rdata;
		end
		if (psel && penable && st_reg.pready && pwrite && !rmiss) begin
			if (paddr[7:6] == scx_pkg::A_AXIS_BLOCK) begin
				case (paddr[3:2])
					scx_pkg::S_SET_CFG: st_next.set_cfg[rax] = pwdata;
					scx_pkg::S_RES_CFG: st_next.res_cfg[rax] = pwdata;
					scx_pkg::S_SHIFT: st_next.shv[rax] = pwdata[15:0];
					default: st_next.shv[rax] = st_reg.shv[rax];
				endcase
			end else begin
				case (paddr)
					scx_pkg::A_CTRL: st_next.ctrl = pwdata[13:0];
					scx_pkg::A_OBJ_SIZE: begin
						st_next.obj_w = pwdata[15:0];
						st_next.obj_h = pwdata[31:16];
					end
					scx_pkg::A_THRESH: st_next.thr = pwdata[7:0];
					scx_pkg::A_AUTO_INC: st_next.inc = pwdata[7:0];
					scx_pkg::A_TIMER: st_next.tper = pwdata[15:0];
					scx_pkg::A_BMP_ADDR: st_next.baddr = pwdata[3:0];
					scx_pkg::A_BMP_DATA: begin
						st_next.bmp[st_reg.baddr] = pwdata;
						st_next.baddr = st_reg.baddr + 4'h1;
					end
					default: st_next.ctrl = st_reg.ctrl;
				endcase
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			st_reg <= '0;
			st_reg.ctrl <= scx_pkg::CTRL_RESET;
			st_reg.tper <= scx_pkg::TIMER_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata = st_reg.prdata;
	assign pready = st_reg.pready;
	assign pslverr = st_reg.pslverr;
	assign laser_on = st_reg.laser;
	assign laser_level = st_reg.level;
	assign shift_pulse = st_reg.shp;
	assign shifter_reset = st_reg.rsp;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	sequence s_plain_inside;
		pix_valid && in_obj && !st_reg.ctrl[scx_pkg::C_BMP_EN];
	endsequence
	sequence s_gt_low;
		pix_valid && in_obj && in_bmp && st_reg.ctrl[scx_pkg::C_BMP_EN] &&
			(mode == scx_pkg::MODE_GT) && (grey <= st_reg.thr);
	endsequence

	chk_plain_exposes: assert property (s_plain_inside |=> laser_on)
		else $error("Object position without bitmap was not exposed.");
	chk_gt_blocks: assert property (s_gt_low |=> !laser_on)
		else $error("Pixel at or below threshold was exposed in greater mode.");
	chk_eq_match: assert property (pix_valid && in_obj && in_bmp && st_reg.ctrl[scx_pkg::C_BMP_EN]
		&& (mode == scx_pkg::MODE_EQ) |=> laser_on == $past(grey == st_reg.thr))
		else $error("Equality mode exposure does not match the threshold test.");
	chk_real_level: assert property (pix_valid && in_obj && in_bmp &&
		st_reg.ctrl[scx_pkg::C_BMP_EN] && (mode == scx_pkg::MODE_REAL)
		|=> laser_level == $past(grey))
		else $error("Analog level differs from the pixel grey value.");
	chk_thr_step: assert property (scan_done && inc_mode && !(psel && penable && pwrite)
		|=> st_reg.thr == $past(st_reg.thr) + $past(st_reg.inc))
		else $error("Threshold did not step by the increment after a scan.");
	chk_scan_count: assert property (scan_done |=> st_reg.scan_cnt == $past(st_reg.scan_cnt) + 32'h1)
		else $error("Scan counter did not advance on a completed scan.");
	chk_shift_move: assert property (shift_pulse[0] && !shifter_reset[0] |->
		st_reg.pos[0] == $past(st_reg.pos[0]) + $past(st_reg.shv[0]))
		else $error("X shifter did not move by its shift value.");
	chk_reset_zero: assert property (shifter_reset[1] |-> st_reg.pos[1] == 16'h0000)
		else $error("Y shifter reset did not return the position to zero.");
	chk_set_reach: assert property ((set_events[2] != 4'h0) && (st_reg.scnt[2] +
		{12'h000, set_events[2]} > st_reg.set_cfg[2][31:16]) |=> shift_pulse[2])
		else $error("Z shifter did not shift when its set count was reached.");
	chk_apb_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
		else $error("APB access was not answered after one wait state.");
endmodule : scx_top
`default_nettype wire

// ### bench/scx_far.sv
// Far-side model: laser modulation input that counts exposure cycles, and axis encoder.
`timescale 1ns/1ps
`default_nettype none
module scx_far (
	input wire logic clock,
	input wire logic laser_on,
	input wire logic enc_go,
	input wire logic [3:0] enc_req,
	output logic enc_edge,
	output logic [31:0] on_cnt
);
	logic [3:0] left;
	initial begin
		enc_edge = 1'b0;
		on_cnt = 32'h0;
		left = 4'h0;
	end
	// Edges come on alternate cycles, as a real encoder never repeats one edge twice.
	always @(posedge clock) begin
		if (laser_on === 1'b1)
			on_cnt <= on_cnt + 32'h1;
		if (enc_go)
			left <= enc_req;
		else if (left != 4'h0 && !enc_edge)
			left <= left - 4'h1;
		enc_edge <= !enc_go && left != 4'h0 && !enc_edge;
	end
endmodule : scx_far
`default_nettype wire

// ### bench/scan_exposure_shift_control_tb.sv
// Self-checking bench for the scan exposure and shifter block.
`timescale 1ns/1ps
`default_nettype none
module scan_exposure_shift_control_tb;
	logic clock = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic pix_valid = 1'b0, enc_go = 1'b0, pready, pslverr, enc_edge, laser_on;
	logic [3:0] enc_req = 4'h0;
	logic [5:0] evs = 6'h0;
	logic [7:0] paddr = 8'h0, laser_level;
	logic [15:0] pix_x = 16'h0, pix_y = 16'h0;
	logic [31:0] pwdata = 32'h0, prdata, on_cnt, rv, re, on, lv, base;
	logic [2:0] shift_pulse, shifter_reset;
	logic [31:0] sp [3] = '{default: 32'h0};
	logic [31:0] rs [3] = '{default: 32'h0};
	int err_total = 0;
	int tests_run = 0;
	scx_top u_dut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pix_valid(pix_valid), .pix_x(pix_x), .pix_y(pix_y),
		.scan_start(evs[0]), .field_done(evs[1]), .line_done(evs[2]), .scan_done(evs[3]),
		.obj_done(evs[4]), .enc_edge(enc_edge), .ext_trig(evs[5]), .laser_on(laser_on),
		.laser_level(laser_level), .shift_pulse(shift_pulse), .shifter_reset(shifter_reset));
	scx_far u_far (.clock(clock), .laser_on(laser_on), .enc_go(enc_go), .enc_req(enc_req),
		.enc_edge(enc_edge), .on_cnt(on_cnt));
	initial begin
		forever #50 clock = ~clock;
	end
	always @(posedge clock) begin
		for (int i = 0; i < 3; i++) begin
			if (shift_pulse[i] === 1'b1)
				sp[i] <= sp[i] + 32'h1;
			if (shifter_reset[i] === 1'b1)
				rs[i] <= rs[i] + 32'h1;
		end
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			err_total++;
			$display("mismatch at %0t: saw %h expected %h", $time, s, e);
		end
	endtask : chk
	// Starts one edge late so a release and a new request never share a time step.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_total++;
			$display("mismatch at %0t: bus wait timed out", $time);
			test_done();
		end
		rv = prdata;
		re = {31'h0, pslverr};
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rv, e);
	endtask : rdc
	function automatic logic [7:0] ax(input logic [1:0] a, input logic [1:0] s);
		return {scx_pkg::A_AXIS_BLOCK, a, s, 2'b00};
	endfunction : ax
	task automatic px(input logic [15:0] x, input logic [15:0] y, input int n);
		@(posedge clock);
		pix_valid <= 1'b1;
		pix_x <= x;
		pix_y <= y;
		repeat (n) @(posedge clock);
		pix_valid <= 1'b0;
		#1;
		on = {31'h0, laser_on};
		lv = {24'h0, laser_level};
	endtask : px
	task automatic pxc(input logic [15:0] x, input logic [15:0] y, input logic e);
		px(x, y, 1);
		chk(on, {31'h0, e});
	endtask : pxc
	task automatic ev(input logic [5:0] m);
		@(posedge clock);
		evs <= m;
		@(posedge clock);
		evs <= 6'h0;
		repeat (4) @(posedge clock);
	endtask : ev
	task automatic enc(input logic [3:0] n);
		@(posedge clock);
		enc_req <= n;
		enc_go <= 1'b1;
		@(posedge clock);
		enc_go <= 1'b0;
		repeat (14) @(posedge clock);
	endtask : enc
	task automatic t_regs;
		rdc(scx_pkg::A_CTRL, 32'h0);
		rdc(scx_pkg::A_TIMER, 32'h3E8);
		wr(scx_pkg::A_OBJ_SIZE, 32'h0002_0002);
		rdc(scx_pkg::A_OBJ_SIZE, 32'h0002_0002);
		wr(8'h70, 32'h1);
		chk(re, 32'h1);
		rdc(8'h70, 32'h0);
		chk(re, 32'h1);
		$display("test registers done");
	endtask : t_regs
	task automatic t_pix;
		wr(scx_pkg::A_BMP_ADDR, 32'h0);
		wr(scx_pkg::A_BMP_DATA, 32'h41);
		wr(scx_pkg::A_BMP_ADDR, 32'h0);
		rdc(scx_pkg::A_BMP_DATA, 32'h41);
		wr(scx_pkg::A_CTRL, 32'h0);
		pxc(16'h1, 16'h1, 1'b1);
		pxc(16'h2, 16'h1, 1'b0);
		wr(scx_pkg::A_OBJ_SIZE, 32'h0010_0010);
		wr(scx_pkg::A_CTRL, 32'h4);
		pxc(16'h0, 16'h0, 1'b1);
		pxc(16'h4, 16'h4, 1'b0);
		wr(scx_pkg::A_CTRL, 32'hC);
		pxc(16'h4, 16'h4, 1'b1);
		wr(scx_pkg::A_CTRL, 32'h14);
		pxc(16'h0, 16'h0, 1'b0);
		pxc(16'h1, 16'h0, 1'b1);
		wr(scx_pkg::A_CTRL, 32'h6);
		pxc(16'h3, 16'h0, 1'b1);
		wr(scx_pkg::A_CTRL, 32'h5);
		pxc(16'h0, 16'h3, 1'b1);
		wr(scx_pkg::A_CTRL, 32'h2604);
		pxc(16'h0, 16'h0, 1'b1);
		wr(scx_pkg::A_CTRL, 32'h2104);
		pxc(16'h0, 16'h0, 1'b0);
		$display("test pixel gating done");
	endtask : t_pix
	task automatic t_grey;
		wr(scx_pkg::A_CTRL, 32'h44);
		px(16'h0, 16'h0, 1);
		chk(lv, 32'h41);
		wr(scx_pkg::A_CTRL, 32'h54);
		px(16'h0, 16'h0, 1);
		chk(lv, 32'hBE);
		wr(scx_pkg::A_CTRL, 32'h64);
		wr(scx_pkg::A_THRESH, 32'h40);
		pxc(16'h0, 16'h0, 1'b1);
		wr(scx_pkg::A_THRESH, 32'h41);
		pxc(16'h0, 16'h0, 1'b0);
		wr(scx_pkg::A_CTRL, 32'h84);
		pxc(16'h0, 16'h0, 1'b1);
		wr(scx_pkg::A_THRESH, 32'h40);
		pxc(16'h0, 16'h0, 1'b0);
		wr(scx_pkg::A_CTRL, 32'hC4);
		wr(scx_pkg::A_THRESH, 32'h3C);
		wr(scx_pkg::A_AUTO_INC, 32'h5);
		pxc(16'h0, 16'h0, 1'b1);
		ev(6'h08);
		rdc(scx_pkg::A_THRESH, 32'h41);
		pxc(16'h0, 16'h0, 1'b0);
		rdc(scx_pkg::A_SCAN_COUNT, 32'h1);
		ev(6'h10);
		rdc(scx_pkg::A_OBJ_COUNT, 32'h1);
		wr(scx_pkg::A_CTRL, 32'h24);
		base = on_cnt;
		px(16'h0, 16'h0, 256);
		@(posedge clock);
		#1;
		chk(on_cnt - base, 32'h41);
		$display("test grey modes done");
	endtask : t_grey
	task automatic t_shift;
		wr(ax(2'h0, scx_pkg::S_SET_CFG), 32'h0001_0004);
		wr(ax(2'h0, scx_pkg::S_SHIFT), 32'h3);
		ev(6'h04);
		chk(sp[0], 32'h0);
		ev(6'h04);
		chk(sp[0], 32'h1);
		rdc(ax(2'h0, scx_pkg::S_POS), 32'h3);
		wr(ax(2'h0, scx_pkg::S_SET_CFG), 32'h0001_0005);
		ev(6'h05);
		chk(sp[0], 32'h2);
		rdc(ax(2'h0, scx_pkg::S_POS), 32'h6);
		wr(ax(2'h0, scx_pkg::S_SET_CFG), 32'h0000_0001);
		ev(6'h01);
		chk(sp[0], 32'h3);
		$display("test shift events done");
	endtask : t_shift
	task automatic t_axes;
		wr(ax(2'h1, scx_pkg::S_SET_CFG), 32'h8);
		enc(4'h3);
		chk(sp[1], 32'h0);
		enc(4'h5);
		chk(sp[1], 32'h2);
		wr(ax(2'h2, scx_pkg::S_SET_CFG), 32'h10);
		wr(ax(2'h2, scx_pkg::S_SHIFT), 32'h5);
		ev(6'h20);
		chk(sp[2], 32'h1);
		rdc(ax(2'h2, scx_pkg::S_POS), 32'h5);
		wr(ax(2'h0, scx_pkg::S_SET_CFG), 32'h80);
		wr(ax(2'h1, scx_pkg::S_SET_CFG), 32'h2);
		wr(ax(2'h2, scx_pkg::S_RES_CFG), 32'h2);
		wr(ax(2'h1, scx_pkg::S_RES_CFG), 32'h2);
		ev(6'h02);
		chk(rs[2], 32'h1);
		chk(rs[1], 32'h1);
		rdc(ax(2'h1, scx_pkg::S_POS), 32'h0);
		rdc(ax(2'h2, scx_pkg::S_POS), 32'h0);
		chk(sp[0], 32'h4);
		chk(sp[1], 32'h3);
		wr(scx_pkg::A_TIMER, 32'hA);
		wr(ax(2'h1, scx_pkg::S_SET_CFG), 32'h20);
		repeat (5) @(posedge clock);
		base = sp[1];
		repeat (30) @(posedge clock);
		chk(sp[1] - base, 32'h3);
		$display("test axis sources done");
	endtask : t_axes
	initial begin
		repeat (16) @(posedge clock);
		resetn <= 1'b1;
		t_regs();
		t_pix();
		t_grey();
		t_shift();
		t_axes();
		test_done();
	end
endmodule : scan_exposure_shift_control_tb
`default_nettype wire
